// [rtl/rmc_regulator_monitor_control.sv]
// Regulator monitor control: control/status register, mode gating, reset and interrupt outputs.
//
// Functional notes
// - Status bit 2 is read-only, follows the monitored supply, writes ignored.
// - Status reads 1 only in full mode, from below assert level until above deassert level, else 0.
// - Enable bit 1 gates the interrupt request raised by a set flag.
// - Flag bit 0 sets on every status change, rising or falling.
// - Flag clears only by writing 1; writing 0 leaves it.
// - Entering reduced-power mode never clears the flag by itself.
// - Detection works only in full-performance mode; a set and enabled flag raises the interrupt in any mode.
// - Status sets below assert level, clears above deassert level, hysteresis.
// - Power-on reset high while core supply low, active in all modes.
// - Power-on reset high holds chip in reset; falling releases start-up.
// - Low-voltage reset asserts below assert level, negates above deassert level.
// - Low-voltage reset only in full mode, never asserts otherwise.
// - Reduced-power mode during stop mode, full mode otherwise, unless shutdown.
`timescale 1ns/10ps
`default_nettype none
`include "rmc_defs.svh"

module rmc_regulator_monitor_control
   import rmc_pkg::*;
#(
   parameter int ADDR_W = `RMC_ADDR_W,
   parameter int DATA_W = `RMC_DATA_W
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic wrEn,
   input wire logic rdEn,
   output logic [DATA_W-1:0] rdData,
   input wire logic regulatorEnableIn,
   input wire logic stopModeIn,
   input wire logic refBelowIrqAssert,
   input wire logic refAboveIrqDeassert,
   input wire logic coreBelowPorRelease,
   input wire logic coreBelowResetAssert,
   input wire logic coreAboveResetDeassert,
   output logic powerOnResetOut,
   output logic lowVoltageResetOut,
   output logic lowVoltageIrq,
   output logic lowVoltageStatus
);

   rmc_ctrl_state_t state_r;
   rmc_ctrl_state_t state_nxt;
   logic [`RMC_CMP_W-1:0] cmpSync;
   logic modeFull;
   logic status;
   logic lvrLevel;
   logic ctrlWrite;
   logic ctrlRead;

   // -----------------------------------------------------------------
   // Address decode.
   // -----------------------------------------------------------------
   function automatic logic hitCtrl(input logic [ADDR_W-1:0] a);
      hitCtrl = (a == ADDR_W'(`RMC_OFFSET_CTRL));
   endfunction : hitCtrl

   assign ctrlWrite = wrEn && hitCtrl(addr);
   assign ctrlRead = rdEn && hitCtrl(addr);
   assign modeFull = (state_r.mode == RMC_FULL_PERF);

   // -----------------------------------------------------------------
   // Comparator synchronisers.
   // -----------------------------------------------------------------
   rmc_sync #(
      .W(`RMC_CMP_W),
      .RESET_VAL(`RMC_CMP_RST)
   ) u_cmpSync (
      .clk(clk),
      .srst(srst),
      .asyncIn({refBelowIrqAssert, refAboveIrqDeassert, coreBelowPorRelease,
                coreBelowResetAssert, coreAboveResetDeassert}),
      .syncOut(cmpSync)
   );

   // -----------------------------------------------------------------
   // Low-voltage detect and low-voltage reset levels.
   // -----------------------------------------------------------------
   rmc_hysteresis u_detect (
      .clk(clk),
      .srst(srst),
      .enable(modeFull),
      .belowAssert(cmpSync[`RMC_CMP_REF_BELOW]),
      .aboveDeassert(cmpSync[`RMC_CMP_REF_ABOVE]),
      .level(status)
   );

   rmc_hysteresis u_lvReset (
      .clk(clk),
      .srst(srst),
      .enable(modeFull),
      .belowAssert(cmpSync[`RMC_CMP_CORE_BELOW]),
      .aboveDeassert(cmpSync[`RMC_CMP_CORE_ABOVE]),
      .level(lvrLevel)
   );

   // -----------------------------------------------------------------
   // Next state.
   // -----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      // Mode selection from the enable pin and the stop mode level.
      if (!regulatorEnableIn)
      begin
         state_nxt.mode = RMC_SHUTDOWN;
      end
      else if (stopModeIn)
      begin
         state_nxt.mode = RMC_REDUCED_PWR;
      end
      else
      begin
         state_nxt.mode = RMC_FULL_PERF;
      end
      // Control writes; the status bit is not writable.
      if (ctrlWrite)
      begin
         state_nxt.irqEnable = wrData[`RMC_BIT_IRQ_EN];
         if (wrData[`RMC_BIT_IRQ_FLAG])
         begin
            state_nxt.irqFlag = 1'b0;
         end
      end
      // A status change sets the flag and wins over a clear.
      state_nxt.statusPrev = status;
      if (status != state_r.statusPrev)
      begin
         state_nxt.irqFlag = 1'b1;
      end
      state_nxt.irq = state_r.irqFlag && state_r.irqEnable;
      state_nxt.por = cmpSync[`RMC_CMP_CORE_POR];
      // Read data stand in the cycle after the read strobe only.
      state_nxt.rdData = `RMC_RD_UNMAPPED;
      if (ctrlRead)
      begin
         state_nxt.rdData[`RMC_BIT_STATUS] = status;
         state_nxt.rdData[`RMC_BIT_IRQ_EN] = state_r.irqEnable;
         state_nxt.rdData[`RMC_BIT_IRQ_FLAG] = state_r.irqFlag;
      end
   end

   // -----------------------------------------------------------------
   // Registers.
   // -----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r.mode <= RMC_FULL_PERF;
         state_r.irqEnable <= `RMC_RST_IRQ_EN;
         state_r.irqFlag <= `RMC_RST_IRQ_FLAG;
         state_r.statusPrev <= `RMC_RST_STATUS;
         state_r.por <= `RMC_RST_POR;
         state_r.irq <= 1'b0;
         state_r.rdData <= `RMC_RD_UNMAPPED;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign rdData = state_r.rdData;
   assign powerOnResetOut = state_r.por;
   assign lowVoltageResetOut = lvrLevel;
   assign lowVoltageIrq = state_r.irq;
   assign lowVoltageStatus = status;

   // -----------------------------------------------------------------
   // Assertions.
   // -----------------------------------------------------------------
   property p_statusOffMode;
      @(posedge clk) disable iff (srst)
      !modeFull |=> !lowVoltageStatus;
   endproperty
   a_statusOffMode: assert property (p_statusOffMode)
      else $error("Status set outside full-performance mode.");

   property p_statusSet;
      @(posedge clk) disable iff (srst)
      modeFull && cmpSync[`RMC_CMP_REF_BELOW] |=> lowVoltageStatus;
   endproperty
   a_statusSet: assert property (p_statusSet)
      else $error("Status not set below assert level.");

   property p_statusClear;
      @(posedge clk) disable iff (srst)
      cmpSync[`RMC_CMP_REF_ABOVE] && !cmpSync[`RMC_CMP_REF_BELOW] |=> !lowVoltageStatus;
   endproperty
   a_statusClear: assert property (p_statusClear)
      else $error("Status not cleared above deassert level.");

   property p_flagOnChange;
      @(posedge clk) disable iff (srst)
      !$stable(lowVoltageStatus) ##1 1'b1 |-> state_r.irqFlag;
   endproperty
   a_flagOnChange: assert property (p_flagOnChange)
      else $error("Flag not set after status change.");

   property p_flagHold;
      @(posedge clk) disable iff (srst)
      state_r.irqFlag && !(ctrlWrite && wrData[`RMC_BIT_IRQ_FLAG]) |=> state_r.irqFlag;
   endproperty
   a_flagHold: assert property (p_flagHold)
      else $error("Flag lost without a write of one.");

   property p_flagClear;
      @(posedge clk) disable iff (srst)
      ctrlWrite && wrData[`RMC_BIT_IRQ_FLAG] && (status == state_r.statusPrev)
         |=> !state_r.irqFlag;
   endproperty
   a_flagClear: assert property (p_flagClear)
      else $error("Write of one did not clear the flag.");

   property p_irqFollows;
      @(posedge clk) disable iff (srst)
      ##1 lowVoltageIrq == ($past(state_r.irqFlag) && $past(state_r.irqEnable));
   endproperty
   a_irqFollows: assert property (p_irqFollows)
      else $error("Interrupt request does not follow flag and enable.");

   property p_porFollows;
      @(posedge clk) disable iff (srst)
      cmpSync[`RMC_CMP_CORE_POR] |=> powerOnResetOut;
   endproperty
   a_porFollows: assert property (p_porFollows)
      else $error("Power-on reset low while core supply below threshold.");

   property p_lvrOffMode;
      @(posedge clk) disable iff (srst)
      !modeFull |=> !lowVoltageResetOut;
   endproperty
   a_lvrOffMode: assert property (p_lvrOffMode)
      else $error("Low-voltage reset outside full-performance mode.");

   property p_lvrAssert;
      @(posedge clk) disable iff (srst)
      modeFull && cmpSync[`RMC_CMP_CORE_BELOW] |=> lowVoltageResetOut;
   endproperty
   a_lvrAssert: assert property (p_lvrAssert)
      else $error("Low-voltage reset not asserted below level.");

   property p_resetQuiet;
      @(posedge clk)
      srst |=> !state_r.irqEnable && !state_r.irqFlag && !lowVoltageIrq;
   endproperty
   a_resetQuiet: assert property (p_resetQuiet)
      else $error("Enable or flag not zero after reset.");

   property p_statusReadOnly;
      @(posedge clk) disable iff (srst)
      ctrlWrite |=> lowVoltageStatus == ($past(modeFull) && ($past(cmpSync[`RMC_CMP_REF_BELOW])
         || ($past(lowVoltageStatus) && !$past(cmpSync[`RMC_CMP_REF_ABOVE]))));
   endproperty
   a_statusReadOnly: assert property (p_statusReadOnly)
      else $error("Write changed the read-only status bit.");

   property p_lvrNegate;
      @(posedge clk) disable iff (srst)
      cmpSync[`RMC_CMP_CORE_ABOVE] && !cmpSync[`RMC_CMP_CORE_BELOW] |=> !lowVoltageResetOut;
   endproperty
   a_lvrNegate: assert property (p_lvrNegate)
      else $error("Low-voltage reset not negated above deassert level.");

   property p_porRelease;
      @(posedge clk) disable iff (srst)
      !cmpSync[`RMC_CMP_CORE_POR] |=> !powerOnResetOut;
   endproperty
   a_porRelease: assert property (p_porRelease)
      else $error("Power-on reset high while core supply above threshold.");

   property p_flagNoEvent;
      @(posedge clk) disable iff (srst)
      !state_r.irqFlag && (status == state_r.statusPrev) |=> !state_r.irqFlag;
   endproperty
   a_flagNoEvent: assert property (p_flagNoEvent)
      else $error("Flag set without a status change.");

   property p_enableWrite;
      @(posedge clk) disable iff (srst)
      ctrlWrite |=> state_r.irqEnable == $past(wrData[`RMC_BIT_IRQ_EN]);
   endproperty
   a_enableWrite: assert property (p_enableWrite)
      else $error("Interrupt enable does not hold the written value.");

   property p_readData;
      @(posedge clk) disable iff (srst)
      ctrlRead |=> (rdData[`RMC_BIT_STATUS] == $past(lowVoltageStatus))
         && (rdData[`RMC_BIT_IRQ_EN] == $past(state_r.irqEnable))
         && (rdData[`RMC_BIT_IRQ_FLAG] == $past(state_r.irqFlag));
   endproperty
   a_readData: assert property (p_readData)
      else $error("Read data do not show status, enable and flag.");

endmodule : rmc_regulator_monitor_control

`default_nettype wire

// [rtl/rmc_defs.svh]
// Register map, field positions, reset values and widths of the regulator monitor control.
`ifndef RMC_DEFS_SVH
`define RMC_DEFS_SVH

`define RMC_ADDR_W 8
`define RMC_DATA_W 8
`define RMC_OFFSET_CTRL 8'h00
`define RMC_RD_UNMAPPED 8'h00
`define RMC_BIT_STATUS 2
`define RMC_BIT_IRQ_EN 1
`define RMC_BIT_IRQ_FLAG 0
`define RMC_RST_IRQ_EN 1'b0
`define RMC_RST_IRQ_FLAG 1'b0
`define RMC_RST_STATUS 1'b0
`define RMC_RST_POR 1'b1
`define RMC_RST_LVR 1'b0
`define RMC_CMP_W 5
`define RMC_CMP_RST 5'h04
`define RMC_CMP_REF_BELOW 4
`define RMC_CMP_REF_ABOVE 3
`define RMC_CMP_CORE_POR 2
`define RMC_CMP_CORE_BELOW 1
`define RMC_CMP_CORE_ABOVE 0

`endif

// [rtl/rmc_pkg.sv]
// Types shared by the regulator monitor control modules.
package rmc_pkg;

   typedef enum logic [1:0] {
      RMC_FULL_PERF,
      RMC_REDUCED_PWR,
      RMC_SHUTDOWN
   } rmc_mode_t;

   typedef struct packed {
      rmc_mode_t mode;
      logic irqEnable;
      logic irqFlag;
      logic statusPrev;
      logic por;
      logic irq;
      logic [7:0] rdData;
   } rmc_ctrl_state_t;

endpackage : rmc_pkg

// [rtl/rmc_sync.sv]
// Two-stage synchroniser for a vector of asynchronous comparator levels.
`timescale 1ns/10ps
`default_nettype none

module rmc_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } rmc_sync_state_t;

   rmc_sync_state_t state_r;
   rmc_sync_state_t state_nxt;

   // -----------------------------------------------------------------
   // Next state.
   // -----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.stage1 = asyncIn;
      state_nxt.stage2 = state_r.stage1;
   end

   // -----------------------------------------------------------------
   // Registers.
   // -----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r.stage1 <= RESET_VAL;
         state_r.stage2 <= RESET_VAL;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign syncOut = state_r.stage2;

endmodule : rmc_sync

`default_nettype wire

// [rtl/rmc_hysteresis.sv]
// Hysteresis level with separate assert and deassert conditions and a mode enable.
`timescale 1ns/10ps
`default_nettype none

module rmc_hysteresis
(
   input wire logic clk,
   input wire logic srst,
   input wire logic enable,
   input wire logic belowAssert,
   input wire logic aboveDeassert,
   output logic level
);

   typedef struct packed {
      logic level;
   } rmc_hyst_state_t;

   rmc_hyst_state_t state_r;
   rmc_hyst_state_t state_nxt;

   // -----------------------------------------------------------------
   // Next state.
   // -----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      if (!enable)
      begin
         state_nxt.level = 1'b0;
      end
      else if (belowAssert)
      begin
         state_nxt.level = 1'b1;
      end
      else if (aboveDeassert)
      begin
         state_nxt.level = 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Registers.
   // -----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r.level <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign level = state_r.level;

endmodule : rmc_hysteresis

`default_nettype wire

// [tb/rmc_supply_model.sv]
// Supply and mode partner that turns millivolt levels into comparator outputs.
`timescale 1ns/10ps
`default_nettype none

module rmc_supply_model
#(
   parameter int IRQ_ASSERT_MV = 4000,
   parameter int IRQ_DEASSERT_MV = 4200,
   parameter int POR_RELEASE_MV = 1500,
   parameter int RST_ASSERT_MV = 2200,
   parameter int RST_DEASSERT_MV = 2300
)
(
   input wire logic [15:0] refMv,
   input wire logic [15:0] coreMv,
   input wire logic shutdownReq,
   output logic regulatorEnableIn,
   output logic refBelowIrqAssert,
   output logic refAboveIrqDeassert,
   output logic coreBelowPorRelease,
   output logic coreBelowResetAssert,
   output logic coreAboveResetDeassert
);
   // ----------------------------------------
   // Comparators and enable pin
   // ----------------------------------------
   assign regulatorEnableIn = ~shutdownReq;
   assign refBelowIrqAssert = (int'(refMv) < IRQ_ASSERT_MV);
   assign refAboveIrqDeassert = (int'(refMv) > IRQ_DEASSERT_MV);
   assign coreBelowPorRelease = (int'(coreMv) < POR_RELEASE_MV);
   assign coreBelowResetAssert = (int'(coreMv) < RST_ASSERT_MV);
   assign coreAboveResetDeassert = (int'(coreMv) > RST_DEASSERT_MV);
endmodule : rmc_supply_model
`default_nettype wire

// [tb/rmc_regulator_monitor_control_test.sv]
// Self-checking bench for the regulator monitor control.
`timescale 1ns/10ps
`default_nettype none
`include "rmc_defs.svh"

module rmc_regulator_monitor_control_test;
   typedef struct packed {
      logic [15:0] refMv;
      logic [15:0] coreMv;
      logic stop;
      logic shut;
      logic status;
      logic low_voltage_reset_out;
      logic por;
   } rmc_row_t;

   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wrData = 8'h00;
   logic wrEn = 1'b0;
   logic rdEn = 1'b0;
   logic [7:0] rdData;
   logic stopModeIn = 1'b0;
   logic shutdownReq = 1'b0;
   logic [15:0] refMv = 16'h1388;
   logic [15:0] coreMv = 16'h09c4;
   logic regulatorEnableIn, refBelowIrqAssert, refAboveIrqDeassert;
   logic coreBelowPorRelease, coreBelowResetAssert, coreAboveResetDeassert;
   logic powerOnResetOut, lowVoltageResetOut, lowVoltageIrq, lowVoltageStatus;
   int fails = 0;
   int compares = 0;
   rmc_row_t rows [14];

   always #5 clk = ~clk;

   rmc_supply_model i_far (.refMv(refMv), .coreMv(coreMv), .shutdownReq(shutdownReq),
      .regulatorEnableIn(regulatorEnableIn), .refBelowIrqAssert(refBelowIrqAssert),
      .refAboveIrqDeassert(refAboveIrqDeassert), .coreBelowPorRelease(coreBelowPorRelease),
      .coreBelowResetAssert(coreBelowResetAssert),
      .coreAboveResetDeassert(coreAboveResetDeassert));

   rmc_regulator_monitor_control i_dut (.clk(clk), .srst(srst), .addr(addr),
      .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
      .regulatorEnableIn(regulatorEnableIn), .stopModeIn(stopModeIn),
      .refBelowIrqAssert(refBelowIrqAssert), .refAboveIrqDeassert(refAboveIrqDeassert),
      .coreBelowPorRelease(coreBelowPorRelease), .coreBelowResetAssert(coreBelowResetAssert),
      .coreAboveResetDeassert(coreAboveResetDeassert), .powerOnResetOut(powerOnResetOut),
      .lowVoltageResetOut(lowVoltageResetOut), .lowVoltageIrq(lowVoltageIrq),
      .lowVoltageStatus(lowVoltageStatus));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      @(negedge clk) chk(rdData, exp);
      @(posedge clk);
      @(negedge clk) chk(rdData, 8'h00);
      @(posedge clk);
   endtask : rd

   task automatic irqIs(input logic e);
      @(negedge clk) chk({7'h00, lowVoltageIrq}, {7'h00, e});
      @(posedge clk);
   endtask : irqIs

   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   initial
   begin
      #200000;
      fails++;
      wrap_up();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rows = '{
         '{16'd5000, 16'd2500, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
         '{16'd3900, 16'd2500, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
         '{16'd4100, 16'd2500, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
         '{16'd4300, 16'd2500, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
         '{16'd3900, 16'd2500, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
         '{16'd3900, 16'd2500, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0},
         '{16'd3900, 16'd2500, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0},
         '{16'd5000, 16'd2100, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
         '{16'd5000, 16'd2250, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
         '{16'd5000, 16'd2400, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
         '{16'd5000, 16'd2100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
         '{16'd5000, 16'd1000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1},
         '{16'd5000, 16'd1000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
         '{16'd5000, 16'd2500, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}};
      tick(16);
      srst <= 1'b0;
      foreach (rows[i])
      begin
         refMv <= rows[i].refMv;
         coreMv <= rows[i].coreMv;
         stopModeIn <= rows[i].stop;
         shutdownReq <= rows[i].shut;
         tick(8);
         @(negedge clk);
         chk({7'h00, lowVoltageStatus}, {7'h00, rows[i].status});
         chk({7'h00, lowVoltageResetOut}, {7'h00, rows[i].low_voltage_reset_out});
         chk({7'h00, powerOnResetOut}, {7'h00, rows[i].por});
         @(posedge clk);
      end
      $display("test mode table done");
      srst <= 1'b1;
      tick(2);
      srst <= 1'b0;
      @(negedge clk);
      chk({4'h0, powerOnResetOut, lowVoltageResetOut, lowVoltageIrq, lowVoltageStatus},
         8'h08);
      @(posedge clk);
      rd(`RMC_OFFSET_CTRL, 8'h00);
      $display("test reset done");
      refMv <= 16'd3900;
      tick(8);
      rd(`RMC_OFFSET_CTRL, 8'h05);
      irqIs(1'b0);
      wr(`RMC_OFFSET_CTRL, 8'h02);
      rd(`RMC_OFFSET_CTRL, 8'h07);
      irqIs(1'b1);
      wr(`RMC_OFFSET_CTRL, 8'h03);
      rd(`RMC_OFFSET_CTRL, 8'h06);
      irqIs(1'b0);
      refMv <= 16'd4300;
      tick(8);
      rd(`RMC_OFFSET_CTRL, 8'h03);
      irqIs(1'b1);
      $display("test flag and enable done");
      stopModeIn <= 1'b1;
      tick(8);
      rd(`RMC_OFFSET_CTRL, 8'h03);
      wr(`RMC_OFFSET_CTRL, 8'h07);
      rd(`RMC_OFFSET_CTRL, 8'h02);
      refMv <= 16'd3900;
      tick(8);
      rd(`RMC_OFFSET_CTRL, 8'h02);
      irqIs(1'b0);
      stopModeIn <= 1'b0;
      tick(8);
      rd(`RMC_OFFSET_CTRL, 8'h07);
      $display("test reduced power done");
      wr(8'h10, 8'h01);
      rd(8'h10, 8'h00);
      rd(`RMC_OFFSET_CTRL, 8'h07);
      $display("test unmapped done");
      wrap_up();
   end
endmodule : rmc_regulator_monitor_control_test
`default_nettype wire
